// ==== rtl/scc_pkg.sv ====
package scc_pkg;
   // register indices (printed offsets are not all multiples of four)
   localparam logic [7:0] SCC_IDX_VECTOR  = 8'h03;
   localparam logic [7:0] SCC_IDX_EOB     = 8'h04;
   localparam logic [7:0] SCC_IDX_STOP    = 8'h05;
   localparam logic [7:0] SCC_IDX_RESUME  = 8'h06;
   localparam logic [7:0] SCC_IDX_BRKLEN  = 8'h07;
   localparam logic [7:0] SCC_IDX_RING    = 8'h08;
   localparam logic [7:0] SCC_IDX_LOWM    = 8'h09;
   localparam logic [7:0] SCC_IDX_HIWM    = 8'h0A;
   localparam logic [7:0] SCC_IDX_CFG1    = 8'h0B;
   localparam logic [7:0] SCC_IDX_CTRL    = 8'h10;
   localparam logic [7:0] SCC_IDX_STAT    = 8'h11;
   localparam logic [7:0] SCC_IDX_MASK    = 8'h12;
   localparam logic [7:0] SCC_IDX_LEVEL   = 8'h13;
   // config byte 1 fields
   localparam int SCC_CFG_UBUF_BIT = 7;
   localparam int SCC_CFG_FLOW_HI  = 6;
   localparam int SCC_CFG_FLOW_LO  = 5;
   localparam int SCC_CFG_RATE_HI  = 4;
   // control register bits
   localparam int SCC_CTRL_GO  = 0;
   localparam int SCC_CTRL_BRK = 1;
   // status bits
   localparam int SCC_ST_URDY = 0;
   localparam int SCC_ST_ILL  = 1;
   localparam int SCC_ST_BRKD = 2;
   localparam logic [7:0] SCC_RESET_BYTE = 8'h00;
   localparam logic [2:0] SCC_STAT_ZERO  = 3'h0;
   // ring block size in bytes
   localparam logic [15:0] SCC_RING_BLOCK = 16'h0080;
   // timing
   localparam int SCC_CLK_HZ    = 20000000;
   localparam int SCC_MS_PER_S  = 1000;
   localparam int SCC_CYC_PER_MS = SCC_CLK_HZ / SCC_MS_PER_S;

   typedef enum logic [1:0] {
      SCC_FLOW_NONE  = 2'b00,
      SCC_FLOW_SOFT  = 2'b01,
      SCC_FLOW_ANY   = 2'b10,
      SCC_FLOW_HARD  = 2'b11
   } scc_flow_t;

   typedef enum logic [0:0] {
      SCC_BRK_IDLE = 1'b0,
      SCC_BRK_SEND = 1'b1
   } scc_brk_t;

   typedef struct packed {
      logic            valid;
      logic [7:0]      data;
   } scc_char_t;

   typedef struct packed {
      logic [7:0]  vector;
      logic [7:0]  end_of_block_char;
      logic [7:0]  stop_c;
      logic [7:0]  resume_c;
      logic [7:0]  brklen;
      logic [7:0]  ring;
      logic [7:0]  lowm;
      logic [7:0]  hiwm;
      logic [7:0]  cfg1;
      logic        go;
      logic        brk_req;
      logic [2:0]  stat;
      logic [2:0]  mask;
      scc_brk_t    brk_st;
      logic [7:0]  ms_left;
      logic [15:0] tick;
      logic        tx_halt;
      logic        rx_suspend;
      logic [31:0] prdata;
      logic        prdata_ok;
      logic [7:0]  iack_vec;
   } scc_state_t;
endpackage

// ==== rtl/scc_config.sv ====
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module scc_config
   import scc_pkg::*;
#(
   parameter int CYC_PER_MS = SCC_CYC_PER_MS
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire scc_char_t   rx_char,
   input  wire logic [15:0] ring_count,
   input  wire logic        iack,
   output logic [7:0]       iack_vector,
   output logic             irq,
   output logic             tx_halted,
   output logic             tx_break,
   output logic             rx_suspend,
   output logic             user_buffer_circular,
   output logic [1:0]       flow_control_method,
   output logic [4:0]       bit_rate,
   output logic [15:0]      ring_bytes,
   output logic             channel_go
);
   scc_state_t q, d;
   logic        wr, rd, hit;
   logic [7:0]  idx;
   logic [15:0] free_bytes;
   scc_flow_t   flow;

   // byte address is four times the register index
   function automatic logic [7:0] byte_of(input logic [31:0] w);
      return w[7:0];
   endfunction

   assign idx  = paddr[9:2];
   assign wr   = psel && penable && pwrite;
   assign rd   = psel && penable && !pwrite;
   assign flow = scc_flow_t'(q.cfg1[SCC_CFG_FLOW_HI:SCC_CFG_FLOW_LO]);
   assign ring_bytes = 16'(q.ring) * SCC_RING_BLOCK;
   assign free_bytes = ring_bytes - ring_count;

   always_comb begin
      unique case (idx)
         SCC_IDX_VECTOR, SCC_IDX_EOB, SCC_IDX_STOP, SCC_IDX_RESUME,
         SCC_IDX_BRKLEN, SCC_IDX_RING, SCC_IDX_LOWM, SCC_IDX_HIWM,
         SCC_IDX_CFG1, SCC_IDX_CTRL, SCC_IDX_STAT, SCC_IDX_MASK,
         SCC_IDX_LEVEL: hit = 1'b1;
         default:       hit = 1'b0;
      endcase
   end

   // whole next state in one place; hardware sets beat software clears
   always_comb begin
      d = q;
      if (wr) begin
         unique case (idx)
            SCC_IDX_VECTOR: d.vector   = byte_of(pwdata);
            SCC_IDX_EOB:    d.end_of_block_char      = byte_of(pwdata);
            SCC_IDX_STOP:   d.stop_c   = byte_of(pwdata);
            SCC_IDX_RESUME: d.resume_c = byte_of(pwdata);
            SCC_IDX_BRKLEN: d.brklen   = byte_of(pwdata);
            SCC_IDX_RING:   d.ring     = byte_of(pwdata);
            SCC_IDX_LOWM:   d.lowm     = byte_of(pwdata);
            SCC_IDX_HIWM:   d.hiwm     = byte_of(pwdata);
            SCC_IDX_CFG1:   d.cfg1     = byte_of(pwdata);
            SCC_IDX_CTRL: begin
               d.go = pwdata[SCC_CTRL_GO];
               if (pwdata[SCC_CTRL_BRK])
                  d.brk_req = 1'b1;
               // channel start checks the ring size field for an illegal zero value
               if (pwdata[SCC_CTRL_GO] && !q.go && q.ring == SCC_RESET_BYTE)
                  d.stat[SCC_ST_ILL] = 1'b1;
            end
            SCC_IDX_STAT:   d.stat = q.stat & ~pwdata[2:0];
            SCC_IDX_MASK:   d.mask = pwdata[2:0];
            default: ;
         endcase
      end
      // re-apply set of illegal flag so a same-cycle clear cannot drop it
      if (wr && idx == SCC_IDX_CTRL && pwdata[SCC_CTRL_GO] && !q.go &&
          q.ring == SCC_RESET_BYTE)
         d.stat[SCC_ST_ILL] = 1'b1;
      // receive character matching
      if (rx_char.valid) begin
         if (q.end_of_block_char != SCC_RESET_BYTE && rx_char.data == q.end_of_block_char)
            d.stat[SCC_ST_URDY] = 1'b1;
         if ((flow == SCC_FLOW_SOFT || flow == SCC_FLOW_ANY) &&
             rx_char.data == q.stop_c)
            d.tx_halt = 1'b1;
         else if (flow == SCC_FLOW_SOFT && rx_char.data == q.resume_c)
            d.tx_halt = 1'b0;
         else if (flow == SCC_FLOW_ANY)
            d.tx_halt = 1'b0;
      end
      if (flow == SCC_FLOW_NONE || flow == SCC_FLOW_HARD)
         d.tx_halt = 1'b0;
      // water marks: hysteresis keeps the line from chattering
      if (flow == SCC_FLOW_NONE)
         d.rx_suspend = 1'b0;
      else if (free_bytes < 16'(q.hiwm))
         d.rx_suspend = 1'b1;
      else if (ring_count < 16'(q.lowm))
         d.rx_suspend = 1'b0;
      // break timer, counted in milliseconds
      unique case (q.brk_st)
         SCC_BRK_IDLE: begin
            if (q.brk_req) begin
               if (q.brklen == SCC_RESET_BYTE) begin
                  d.brk_req = 1'b0;
               end else begin
                  d.brk_st  = SCC_BRK_SEND;
                  d.ms_left = q.brklen;
                  d.tick    = 16'(CYC_PER_MS - 1);
               end
            end
         end
         SCC_BRK_SEND: begin
            if (q.tick != 16'h0000) begin
               d.tick = q.tick - 16'h0001;
            end else if (q.ms_left == 8'h01) begin
               d.brk_st  = SCC_BRK_IDLE;
               d.brk_req = 1'b0;
               d.stat[SCC_ST_BRKD] = 1'b1;
            end else begin
               d.ms_left = q.ms_left - 8'h01;
               d.tick    = 16'(CYC_PER_MS - 1);
            end
         end
      endcase
      if (iack)
         d.iack_vec = q.vector;
      // registered read data; ready follows one cycle after the access
      // starts and drops again so back-to-back reads each wait once
      d.prdata_ok = rd && !q.prdata_ok;
      d.prdata = 32'h0000_0000;
      if (rd) begin
         unique case (idx)
            SCC_IDX_VECTOR: d.prdata[7:0] = q.vector;
            SCC_IDX_EOB:    d.prdata[7:0] = q.end_of_block_char;
            SCC_IDX_STOP:   d.prdata[7:0] = q.stop_c;
            SCC_IDX_RESUME: d.prdata[7:0] = q.resume_c;
            SCC_IDX_BRKLEN: d.prdata[7:0] = q.brklen;
            SCC_IDX_RING:   d.prdata[7:0] = q.ring;
            SCC_IDX_LOWM:   d.prdata[7:0] = q.lowm;
            SCC_IDX_HIWM:   d.prdata[7:0] = q.hiwm;
            SCC_IDX_CFG1:   d.prdata[7:0] = q.cfg1;
            SCC_IDX_CTRL:   d.prdata[1:0] = {q.brk_req, q.go};
            SCC_IDX_STAT:   d.prdata[2:0] = q.stat;
            SCC_IDX_MASK:   d.prdata[2:0] = q.mask;
            SCC_IDX_LEVEL:  d.prdata[3:0] = {q.rx_suspend, q.tx_halt,
                                             q.brk_st == SCC_BRK_SEND, irq};
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // read data is registered, so every read takes one wait state; writes take none
   assign pready  = psel && penable && (pwrite || q.prdata_ok);
   assign prdata  = q.prdata;
   assign pslverr = pready && !hit;
   assign irq     = |(q.stat & q.mask);
   assign iack_vector = q.iack_vec;
   assign tx_halted   = q.tx_halt;
   assign tx_break    = q.brk_st == SCC_BRK_SEND;
   assign rx_suspend  = q.rx_suspend;
   assign user_buffer_circular = q.cfg1[SCC_CFG_UBUF_BIT];
   assign flow_control_method  = q.cfg1[SCC_CFG_FLOW_HI:SCC_CFG_FLOW_LO];
   assign bit_rate    = q.cfg1[SCC_CFG_RATE_HI:0];
   assign channel_go  = q.go;

   stop_halts_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_char.valid && rx_char.data == q.stop_c &&
      (flow == SCC_FLOW_SOFT || flow == SCC_FLOW_ANY) |=> tx_halted)
      else $error("stop character did not halt transmit");
   resume_runs_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_char.valid && flow == SCC_FLOW_SOFT && rx_char.data == q.resume_c &&
      rx_char.data != q.stop_c |=> !tx_halted)
      else $error("resume character did not restart transmit");
   eob_ready_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_char.valid && q.end_of_block_char != 8'h00 && rx_char.data == q.end_of_block_char
      |=> q.stat[SCC_ST_URDY])
      else $error("end-of-block did not set ready");
   brk_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      !tx_break && q.brk_req && q.brklen == 8'h00 |=> !q.brk_req)
      else $error("zero break length left request set");
   brk_start_a: assert property (@(posedge sys_clk) disable iff (rst)
      !tx_break && q.brk_req && q.brklen != 8'h00 |=> tx_break)
      else $error("break did not start");
   brk_end_a: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(tx_break) |-> !q.brk_req)
      else $error("break request not cleared at end");
   ill_go_a: assert property (@(posedge sys_clk) disable iff (rst)
      wr && idx == SCC_IDX_CTRL && pwdata[0] && !q.go && q.ring == 8'h00
      |=> q.stat[SCC_ST_ILL])
      else $error("zero ring at go did not flag illegal");
   irq_level_a: assert property (@(posedge sys_clk) disable iff (rst)
      q.stat[SCC_ST_URDY] && q.mask[SCC_ST_URDY] |-> irq)
      else $error("interrupt level wrong");
   suspend_a: assert property (@(posedge sys_clk) disable iff (rst)
      flow != SCC_FLOW_NONE && free_bytes < 16'(q.hiwm)
      |=> rx_suspend)
      else $error("high mark did not suspend input");
   vector_a: assert property (@(posedge sys_clk) disable iff (rst)
      iack |=> iack_vector == $past(q.vector))
      else $error("wrong acknowledge vector");
endmodule
`default_nettype wire

// ==== tb/scc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module scc_host
   import scc_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   output logic             iack,
   output var scc_char_t    rx_char
);
   // idle bus and quiet receive line at time zero
   initial begin
      {psel, penable, pwrite, iack} = 4'h0;
      {paddr, pwdata} = '0;
      rx_char = '0;
   end

   // one transfer, held until pready is seen high at an edge or 100 edges have passed
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
      int n;
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'h1 && n < 100);
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // released lines must not keep looking valid
      paddr <= ~paddr;
      pwdata <= ~pwdata;
   endtask

   // one received character, a single-cycle pulse
   task automatic send(input logic [7:0] c);
      @(posedge sys_clk);
      rx_char <= '{valid: 1'h1, data: c};
      @(posedge sys_clk);
      rx_char <= '{valid: 1'h0, data: ~c};
   endtask

   // interrupt acknowledge pulse
   task automatic ack();
      @(posedge sys_clk);
      iack <= 1'h1;
      @(posedge sys_clk);
      iack <= 1'h0;
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top
   import scc_pkg::*;
;
   localparam int CPM = 4;
   logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic        iack, irq, tx_halted, tx_break, rx_suspend;
   logic        user_buffer_circular, channel_go;
   logic [1:0]  flow_control_method;
   logic [4:0]  bit_rate;
   logic [7:0]  iack_vector;
   logic [11:0] paddr;
   logic [15:0] ring_count, ring_bytes;
   logic [31:0] pwdata, prdata, rdv;
   logic [31:0] seed = 32'h0000202D;
   scc_char_t   rx_char;
   int          mismatches = 0, check_count = 0, n, mdl[16];

   // short millisecond so a break lasts a few cycles
   scc_config #(.CYC_PER_MS(CPM)) u_dut (
      .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .rx_char, .ring_count, .iack, .iack_vector, .irq,
      .tx_halted, .tx_break, .rx_suspend, .user_buffer_circular,
      .flow_control_method, .bit_rate, .ring_bytes, .channel_go
   );
   scc_host u_host (
      .sys_clk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite,
      .paddr, .pwdata, .iack, .rx_char
   );

   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      u_host.xfer(1'h1, idx, d, rdv, err);
   endtask
   task automatic rd(input logic [7:0] idx);
      u_host.xfer(1'h0, idx, 32'h0, rdv, err);
   endtask

   // whole run is far below this; a hang lands here
   initial begin
      #(50 * 20000);
      mismatches++;
      test_done();
   end

   initial begin
      rst = 1'h1;
      ring_count = 16'h0000;
      repeat (5) @(posedge sys_clk);
      rst <= 1'h0;
      // clear after reset, then random contents; ring kept small
      for (int i = 3; i < 12; i++) begin
         rd(8'(i));
         `CHK(rdv, 1'h0);
         mdl[i] = (i == 8) ? 1 + xs() % 8 : xs() % 256;
         wr(8'(i), 32'(mdl[i]));
      end
      for (int i = 3; i < 12; i++) begin
         rd(8'(i));
         `CHK(rdv, mdl[i]);
         `CHK(err, 1'h0);
      end
      @(negedge sys_clk);
      `CHK(ring_bytes, mdl[8] * 128);
      `CHK({user_buffer_circular, flow_control_method, bit_rate}, mdl[11]);
      rd(8'h3F);
      `CHK(err, 1'h1);
      $display("test registers done");
      // only codes 01 and 10 obey the stop character
      wr(SCC_IDX_STOP, 32'h13);
      wr(SCC_IDX_RESUME, 32'h11);
      wr(SCC_IDX_EOB, 32'h00);
      for (int m = 0; m < 4; m++) begin
         wr(SCC_IDX_CFG1, 32'(m << 5));
         u_host.send(8'h13);
         @(negedge sys_clk);
         `CHK(tx_halted, m == 1 || m == 2);
         u_host.send(8'h11);
         @(negedge sys_clk);
         `CHK(tx_halted, 1'h0);
      end
      $display("test flow done");
      // end-of-block seen with receive interrupt on, then off
      wr(SCC_IDX_EOB, 32'h0D);
      wr(SCC_IDX_STAT, 32'h07);
      for (int k = 1; k >= 0; k--) begin
         wr(SCC_IDX_MASK, 32'(k));
         u_host.send(8'h0D);
         @(negedge sys_clk);
         `CHK(irq, k);
         rd(SCC_IDX_STAT);
         `CHK(rdv[SCC_ST_URDY], 1'h1);
         wr(SCC_IDX_STAT, 32'h01);
         @(negedge sys_clk);
         `CHK(irq, 1'h0);
      end
      $display("test receive done");
      // two-millisecond break, then a zero-length one
      for (int b = 2; b >= 0; b -= 2) begin
         wr(SCC_IDX_BRKLEN, 32'(b));
         wr(SCC_IDX_CTRL, 32'h02);
         for (n = 0; n < 8 && tx_break !== 1'h1; n++) @(negedge sys_clk);
         for (n = 0; n < 3000 && tx_break === 1'h1; n++) @(negedge sys_clk);
         `CHK(n, b * CPM);
         rd(SCC_IDX_CTRL);
         `CHK(rdv[SCC_CTRL_BRK], 1'h0);
      end
      $display("test break done");
      // one-block ring: 8 free is under 32, 10 stored under 16
      wr(SCC_IDX_RING, 32'h01);
      wr(SCC_IDX_LOWM, 32'h10);
      wr(SCC_IDX_HIWM, 32'h20);
      ring_count <= 16'h0078;
      repeat (2) @(negedge sys_clk);
      `CHK(rx_suspend, 1'h1);
      @(posedge sys_clk);
      ring_count <= 16'h000A;
      repeat (2) @(negedge sys_clk);
      `CHK(rx_suspend, 1'h0);
      // acknowledge returns the stored vector
      mdl[3] = xs() % 256;
      wr(SCC_IDX_VECTOR, 32'(mdl[3]));
      u_host.ack();
      @(negedge sys_clk);
      `CHK(iack_vector, mdl[3]);
      // start with a zero ring size is flagged
      wr(SCC_IDX_RING, 32'h00);
      wr(SCC_IDX_CTRL, 32'h01);
      repeat (2) @(negedge sys_clk);
      rd(SCC_IDX_STAT);
      `CHK(rdv[SCC_ST_ILL], 1'h1);
      `CHK(channel_go, 1'h1);
      $display("test misc done");
      test_done();
   end
endmodule
`default_nettype wire
